/* File: design/efr_pkg.sv */
// Shared constants and carrier types for the earth-fault stage and recorder
package efr_pkg;

  // ************************************************************
  // Clock and time base
  // ************************************************************
  localparam int CLK_PERIOD_NS = 32'h0000_000A;
  localparam int MS_NS         = 32'h000F_4240;
  localparam int MS_CYCLES     = MS_NS / CLK_PERIOD_NS;

  // ************************************************************
  // Operate delay range, in milliseconds
  // ************************************************************
  localparam int                 DELAY_W      = 17;
  localparam logic [DELAY_W-1:0] DELAY_MIN_MS = 17'h0_001E;
  localparam logic [DELAY_W-1:0] DELAY_MAX_MS = 17'h1_86A0;

  // ************************************************************
  // Sample widths and channel layout
  // ************************************************************
  localparam int SMP_W      = 16;
  localparam int RES_W      = SMP_W + 2;
  localparam int N_PHASE    = 6;
  localparam int N_NEUTRAL  = 2;
  localparam int N_SIDE     = 2;
  localparam int SIDE_HV    = 0;
  localparam int SIDE_LV    = 1;
  localparam int PH_PER_SIDE = 3;
  localparam int N_CTRL     = 5;
  localparam int N_BIN      = 2 * N_SIDE + N_CTRL;
  localparam int PCT_W      = 8;
  localparam int PROD_W     = SMP_W + PCT_W;
  localparam logic [PCT_W-1:0] PCT_FULL = 8'h64;

  // ************************************************************
  // Recorder geometry
  // ************************************************************
  localparam int REC_CYCLES   = 32'h0000_001E;
  localparam int SMP_PER_CYC  = 32'h0000_0028;
  localparam int REC_DEPTH    = REC_CYCLES * SMP_PER_CYC;
  localparam int REC_AW       = $clog2(REC_DEPTH);
  localparam int REC_W        = (N_PHASE + N_NEUTRAL) * SMP_W + N_BIN;

  // ************************************************************
  // Types
  // ************************************************************
  typedef struct packed {
    logic [N_PHASE-1:0][SMP_W-1:0]   phase;
    logic [N_NEUTRAL-1:0][SMP_W-1:0] neutral;
  } efr_samples_t;

  typedef struct packed {
    logic [N_SIDE-1:0][SMP_W-1:0] fund;
    logic [N_SIDE-1:0][SMP_W-1:0] h2;
  } efr_harm_t;

  typedef struct packed {
    logic               residual_sel;
    logic               blk_en;
    logic [SMP_W-1:0]   threshold;
    logic [DELAY_W-1:0] delay_ms;
    logic [PCT_W-1:0]   h2_ratio_pct;
  } efr_side_cfg_t;

  typedef enum logic [1:0] {
    REC_ARMED   = 2'b00,
    REC_CAPTURE = 2'b01,
    REC_FULL    = 2'b10
  } efr_rec_state_t;

endpackage

/* File: design/efr_optimer.sv */
// Definite-time operate timer for one earth-fault side
`timescale 1ns/1ps
module efr_optimer (
  // Clock and reset
  input  wire logic                        clk_sys,
  input  wire logic                        sys_rst,
  // Timing
  input  wire logic                        ms_tick,
  input  wire logic                        start_in,
  input  wire logic [efr_pkg::DELAY_W-1:0] delay_ms,
  // Result
  output logic                             operate
);

  logic [efr_pkg::DELAY_W-1:0] cnt_ff;
  logic [efr_pkg::DELAY_W-1:0] nxt_cnt;
  logic [efr_pkg::DELAY_W-1:0] eff_delay;
  logic                        op_ff;
  logic                        nxt_op;

  always_comb begin
    // Settings outside the range are clamped to its ends
    eff_delay = delay_ms;
    if (delay_ms < efr_pkg::DELAY_MIN_MS) begin
      eff_delay = efr_pkg::DELAY_MIN_MS;
    end else if (delay_ms > efr_pkg::DELAY_MAX_MS) begin
      eff_delay = efr_pkg::DELAY_MAX_MS;
    end
    if (!start_in) begin
      nxt_cnt = '0;
    end else if (ms_tick && (cnt_ff < efr_pkg::DELAY_MAX_MS)) begin
      nxt_cnt = cnt_ff + 17'h0_0001;
    end else begin
      nxt_cnt = cnt_ff;
    end
    // Operate falls on the same edge as start, never one later
    nxt_op = start_in && (nxt_cnt >= eff_delay);
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_ff <= '0;
      op_ff  <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      op_ff  <= nxt_op;
    end
  end

  assign operate = op_ff;

endmodule

/* File: design/efr_recmem.sv */
// Single-record sample memory with synchronous read port
`timescale 1ns/1ps
module efr_recmem #(
  parameter int W     = efr_pkg::REC_W,
  parameter int DEPTH = efr_pkg::REC_DEPTH,
  parameter int AW    = efr_pkg::REC_AW
) (
  // Clock
  input  wire logic          clk_sys,
  // Write side
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [W-1:0]  wr_data,
  // Read side
  input  wire logic [AW-1:0] rd_addr,
  output logic [W-1:0]       rd_data
);

  // No reset on the array: it is only read back after a full capture
  logic [W-1:0] mem [DEPTH];
  logic [W-1:0] rd_ff;

  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_ff <= mem[rd_addr];
  end

  assign rd_data = rd_ff;

endmodule

/* File: design/efr_top.sv */
// Earth-fault stage for HV and LV sides with a disturbance recorder
`timescale 1ns/1ps
module efr_top #(
  parameter int TICK_CYCLES = efr_pkg::MS_CYCLES
) (
  // Clock and reset
  input  wire logic                          clk_sys,
  input  wire logic                          sys_rst,
  // Sampled currents, one strobe per sample at 40 per mains cycle
  input  wire logic                          sample_stb,
  input  wire efr_pkg::efr_samples_t         samples,
  input  wire efr_pkg::efr_harm_t            harm,
  input  wire logic [efr_pkg::N_CTRL-1:0]    ctrl_in,
  // Side settings
  input  wire efr_pkg::efr_side_cfg_t        hv_cfg,
  input  wire efr_pkg::efr_side_cfg_t        lv_cfg,
  // Recorder control
  input  wire logic [efr_pkg::N_BIN-1:0]     trig_mask,
  input  wire logic [efr_pkg::N_BIN-1:0]     trig_rise,
  input  wire logic                          rec_clear,
  input  wire logic [efr_pkg::REC_AW-1:0]    rd_addr,
  // Protection outputs
  output logic                               hv_start,
  output logic                               hv_operate,
  output logic                               hv_block,
  output logic                               lv_start,
  output logic                               lv_operate,
  output logic                               lv_block,
  // Recorder status and readout
  output logic                               rec_busy,
  output logic                               rec_full,
  output logic [efr_pkg::N_BIN-1:0]          rec_trig_src,
  output logic [efr_pkg::REC_W-1:0]          rec_rd_data
);

  // ************************************************************
  // Millisecond time base
  // ************************************************************
  localparam int TICK_W = $clog2(TICK_CYCLES + 1);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

  logic [TICK_W-1:0] tick_cnt_ff;
  logic [TICK_W-1:0] nxt_tick_cnt;
  logic              tick_ff;
  logic              nxt_tick;

  always_comb begin
    nxt_tick = 1'b0;
    if (tick_cnt_ff == TICK_LAST) begin
      nxt_tick_cnt = '0;
      nxt_tick     = 1'b1;
    end else begin
      nxt_tick_cnt = tick_cnt_ff + TICK_W'(1);
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      tick_cnt_ff <= '0;
      tick_ff     <= 1'b0;
    end else begin
      tick_cnt_ff <= nxt_tick_cnt;
      tick_ff     <= nxt_tick;
    end
  end

  // ************************************************************
  // Per-side start, blocking and operate
  // ************************************************************
  efr_pkg::efr_side_cfg_t          cfg [efr_pkg::N_SIDE];
  logic [efr_pkg::N_SIDE-1:0]      start_ff;
  logic [efr_pkg::N_SIDE-1:0]      nxt_start;
  logic [efr_pkg::N_SIDE-1:0]      blk_ff;
  logic [efr_pkg::N_SIDE-1:0]      nxt_blk;
  logic [efr_pkg::N_SIDE-1:0]      operate_w;

  // Each side reads only its own settings and channels
  assign cfg[efr_pkg::SIDE_HV] = hv_cfg;
  assign cfg[efr_pkg::SIDE_LV] = lv_cfg;

  genvar s;
  generate
    for (s = 0; s < efr_pkg::N_SIDE; s++) begin : g_side
      logic signed [efr_pkg::RES_W-1:0]  resid;
      logic        [efr_pkg::RES_W-1:0]  resid_mag;
      logic        [efr_pkg::RES_W-1:0]  neut_mag;
      logic        [efr_pkg::RES_W-1:0]  meas_mag;
      logic        [efr_pkg::PROD_W-1:0] h2_scaled;
      logic        [efr_pkg::PROD_W-1:0] fund_scaled;
      logic                              over;
      logic                              harm_hit;

      always_comb begin
        resid = efr_pkg::RES_W'($signed(samples.phase[s*efr_pkg::PH_PER_SIDE]))
              + efr_pkg::RES_W'($signed(samples.phase[s*efr_pkg::PH_PER_SIDE+1]))
              + efr_pkg::RES_W'($signed(samples.phase[s*efr_pkg::PH_PER_SIDE+2]));
        // Sum of three 16-bit samples never reaches the negative limit
        resid_mag = resid[efr_pkg::RES_W-1] ? efr_pkg::RES_W'(-resid)
                                            : efr_pkg::RES_W'(resid);
        neut_mag  = samples.neutral[s][efr_pkg::SMP_W-1]
                  ? efr_pkg::RES_W'(-efr_pkg::RES_W'($signed(samples.neutral[s])))
                  : efr_pkg::RES_W'(samples.neutral[s]);
        meas_mag  = cfg[s].residual_sel ? resid_mag : neut_mag;
        over      = meas_mag > efr_pkg::RES_W'(cfg[s].threshold);
        // Ratio test without a divider: h2 * 100 > pct * fund
        h2_scaled   = efr_pkg::PROD_W'(harm.h2[s]) * efr_pkg::PROD_W'(efr_pkg::PCT_FULL);
        fund_scaled = efr_pkg::PROD_W'(harm.fund[s])
                    * efr_pkg::PROD_W'(cfg[s].h2_ratio_pct);
        harm_hit    = h2_scaled > fund_scaled;
      end

      always_comb begin
        nxt_start[s] = start_ff[s];
        nxt_blk[s]   = blk_ff[s];
        if (sample_stb) begin
          // Internally formed residual cannot be blocked
          nxt_blk[s]   = cfg[s].blk_en && !cfg[s].residual_sel && harm_hit;
          nxt_start[s] = over && !nxt_blk[s];
        end
      end

      always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
          start_ff[s] <= 1'b0;
          blk_ff[s]   <= 1'b0;
        end else begin
          start_ff[s] <= nxt_start[s];
          blk_ff[s]   <= nxt_blk[s];
        end
      end

      // Fed with the next start so operate and start fall together
      efr_optimer u_timer (
        .clk_sys  (clk_sys),
        .sys_rst  (sys_rst),
        .ms_tick  (tick_ff),
        .start_in (nxt_start[s]),
        .delay_ms (cfg[s].delay_ms),
        .operate  (operate_w[s])
      );
    end
  endgenerate

  assign hv_start   = start_ff[efr_pkg::SIDE_HV];
  assign hv_block   = blk_ff[efr_pkg::SIDE_HV];
  assign hv_operate = operate_w[efr_pkg::SIDE_HV];
  assign lv_start   = start_ff[efr_pkg::SIDE_LV];
  assign lv_block   = blk_ff[efr_pkg::SIDE_LV];
  assign lv_operate = operate_w[efr_pkg::SIDE_LV];

  // ************************************************************
  // Recorder trigger
  // ************************************************************
  logic [efr_pkg::N_BIN-1:0] bin_now;
  logic [efr_pkg::N_BIN-1:0] bin_prev_ff;
  logic [efr_pkg::N_BIN-1:0] nxt_bin_prev;
  logic [efr_pkg::N_BIN-1:0] edge_hit;

  assign bin_now = {ctrl_in, blk_ff, start_ff};

  genvar b;
  generate
    for (b = 0; b < efr_pkg::N_BIN; b++) begin : g_edge
      always_comb begin
        edge_hit[b] = trig_mask[b]
                    && (trig_rise[b] ? (bin_now[b] && !bin_prev_ff[b])
                                     : (!bin_now[b] && bin_prev_ff[b]));
      end
    end
  endgenerate

  always_comb begin
    nxt_bin_prev = bin_now;
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      bin_prev_ff <= '0;
    end else begin
      bin_prev_ff <= nxt_bin_prev;
    end
  end

  // ************************************************************
  // Recorder control
  // ************************************************************
  localparam logic [efr_pkg::REC_AW-1:0] REC_LAST =
    efr_pkg::REC_AW'(efr_pkg::REC_DEPTH - 1);

  efr_pkg::efr_rec_state_t     rec_state_ff;
  efr_pkg::efr_rec_state_t     nxt_rec_state;
  logic [efr_pkg::REC_AW-1:0]  wr_addr_ff;
  logic [efr_pkg::REC_AW-1:0]  nxt_wr_addr;
  logic [efr_pkg::N_BIN-1:0]   trig_src_ff;
  logic [efr_pkg::N_BIN-1:0]   nxt_trig_src;
  logic                        busy_ff;
  logic                        nxt_busy;
  logic                        full_ff;
  logic                        nxt_full;
  logic                        wr_en;
  logic [efr_pkg::REC_W-1:0]   wr_word;

  // Binary channels ride beside the currents in every stored word
  assign wr_word = {bin_now, samples.neutral, samples.phase};

  always_comb begin
    nxt_rec_state = rec_state_ff;
    nxt_wr_addr   = wr_addr_ff;
    nxt_trig_src  = trig_src_ff;
    wr_en         = 1'b0;
    unique case (rec_state_ff)
      efr_pkg::REC_ARMED: begin
        if (|edge_hit) begin
          nxt_rec_state = efr_pkg::REC_CAPTURE;
          nxt_trig_src  = edge_hit;
          nxt_wr_addr   = '0;
        end
      end
      efr_pkg::REC_CAPTURE: begin
        // One word per sample strobe gives 40 words per mains cycle
        if (sample_stb) begin
          wr_en = 1'b1;
          if (wr_addr_ff == REC_LAST) begin
            nxt_rec_state = efr_pkg::REC_FULL;
          end else begin
            nxt_wr_addr = wr_addr_ff + efr_pkg::REC_AW'(1);
          end
        end
      end
      efr_pkg::REC_FULL: begin
        // Triggers are ignored here so the held record is never overwritten
        if (rec_clear) begin
          nxt_rec_state = efr_pkg::REC_ARMED;
          nxt_trig_src  = '0;
          nxt_wr_addr   = '0;
        end
      end
      default: begin
        nxt_rec_state = efr_pkg::REC_ARMED;
      end
    endcase
    nxt_busy = nxt_rec_state == efr_pkg::REC_CAPTURE;
    nxt_full = nxt_rec_state == efr_pkg::REC_FULL;
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rec_state_ff <= efr_pkg::REC_ARMED;
      wr_addr_ff   <= '0;
      trig_src_ff  <= '0;
      busy_ff      <= 1'b0;
      full_ff      <= 1'b0;
    end else begin
      rec_state_ff <= nxt_rec_state;
      wr_addr_ff   <= nxt_wr_addr;
      trig_src_ff  <= nxt_trig_src;
      busy_ff      <= nxt_busy;
      full_ff      <= nxt_full;
    end
  end

  assign rec_busy     = busy_ff;
  assign rec_full     = full_ff;
  assign rec_trig_src = trig_src_ff;

  // ************************************************************
  // Record storage and readout
  // ************************************************************
  efr_recmem #(
    .W     (efr_pkg::REC_W),
    .DEPTH (efr_pkg::REC_DEPTH),
    .AW    (efr_pkg::REC_AW)
  ) u_mem (
    .clk_sys (clk_sys),
    .wr_en   (wr_en),
    .wr_addr (wr_addr_ff),
    .wr_data (wr_word),
    .rd_addr (rd_addr),
    .rd_data (rec_rd_data)
  );

endmodule

/* File: sim/efr_chk_assertions.sv */
// Concurrent checks on the ports of the earth-fault stage
`timescale 1ns/1ps
module efr_chk #(
  parameter int TICK_CYCLES = efr_pkg::MS_CYCLES
) (
  // Clock and reset
  input wire logic                   clk_sys,
  input wire logic                   sys_rst,
  // Inputs
  input wire logic                   sample_stb,
  input wire efr_pkg::efr_samples_t  samples,
  input wire efr_pkg::efr_harm_t     harm,
  input wire logic [4:0]             ctrl_in,
  input wire efr_pkg::efr_side_cfg_t hv_cfg,
  input wire efr_pkg::efr_side_cfg_t lv_cfg,
  input wire logic [8:0]             trig_mask,
  input wire logic [8:0]             trig_rise,
  input wire logic                   rec_clear,
  // Outputs
  input wire logic                   hv_start,
  input wire logic                   hv_operate,
  input wire logic                   hv_block,
  input wire logic                   lv_start,
  input wire logic                   lv_operate,
  input wire logic                   lv_block,
  input wire logic                   rec_busy,
  input wire logic                   rec_full,
  input wire logic [8:0]             rec_trig_src
);
  // ********
  // Helpers
  // ********
  function automatic logic blk_f(efr_pkg::efr_side_cfg_t c, logic [15:0] f, logic [15:0] h);
    return c.blk_en && !c.residual_sel && (32'(h) * 32'h64 > 32'(c.h2_ratio_pct) * 32'(f));
  endfunction
  function automatic logic st_f(efr_pkg::efr_side_cfg_t c, logic [15:0] a, b, d, n, logic k);
    logic signed [17:0] s;
    s = c.residual_sel ? 18'(signed'(a)) + 18'(signed'(b)) + 18'(signed'(d)) : 18'(signed'(n));
    return ((s < 0) ? -s : s) > $signed({2'b00, c.threshold}) && !k;
  endfunction
  // Window allows the early first tick and the register stages
  function automatic longint lim_f(logic [16:0] d, int k);
    longint m;
    m = (d < efr_pkg::DELAY_MIN_MS) ? efr_pkg::DELAY_MIN_MS :
        (d > efr_pkg::DELAY_MAX_MS) ? efr_pkg::DELAY_MAX_MS : d;
    return (m + k) * TICK_CYCLES + 2 * (2 * k + 1);
  endfunction
  logic        hv_bk, lv_bk, hv_ex, lv_ex;
  logic [8:0]  bin_now, hit, bin_ff, nxt_bin;
  logic [31:0] hv_cnt_ff, lv_cnt_ff, wc_ff, nxt_hv_cnt, nxt_lv_cnt, nxt_wc;
  assign hv_bk = blk_f(hv_cfg, harm.fund[0], harm.h2[0]);
  assign lv_bk = blk_f(lv_cfg, harm.fund[1], harm.h2[1]);
  assign hv_ex = st_f(hv_cfg, samples.phase[0], samples.phase[1], samples.phase[2],
                      samples.neutral[0], hv_bk);
  assign lv_ex = st_f(lv_cfg, samples.phase[3], samples.phase[4], samples.phase[5],
                      samples.neutral[1], lv_bk);
  assign bin_now = {ctrl_in, lv_block, hv_block, lv_start, hv_start};
  assign hit = trig_mask & ((trig_rise & bin_now & ~bin_ff) | (~trig_rise & ~bin_now & bin_ff));
  always_comb begin
    nxt_bin = bin_now;
    nxt_hv_cnt = hv_start ? hv_cnt_ff + 32'h1 : 32'h0;
    nxt_lv_cnt = lv_start ? lv_cnt_ff + 32'h1 : 32'h0;
    nxt_wc = rec_busy ? wc_ff + 32'(sample_stb) : 32'h0;
  end
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      bin_ff <= '0;
      hv_cnt_ff <= '0;
      lv_cnt_ff <= '0;
      wc_ff <= '0;
    end else begin
      bin_ff <= nxt_bin;
      hv_cnt_ff <= nxt_hv_cnt;
      lv_cnt_ff <= nxt_lv_cnt;
      wc_ff <= nxt_wc;
    end
  end
  // ********
  // Assertions
  // ********
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  hv_start_calc_a: assert property (
    sample_stb |=> hv_start == $past(hv_ex)) else $error("hv start mismatch");
  lv_start_calc_a: assert property (
    sample_stb |=> lv_start == $past(lv_ex)) else $error("lv start mismatch");
  hv_block_calc_a: assert property (
    sample_stb && !hv_cfg.residual_sel |=> hv_block == $past(hv_bk)) else $error("hv block");
  lv_block_calc_a: assert property (
    sample_stb |=> lv_block == $past(lv_bk)) else $error("lv block");
  start_hold_a: assert property (
    !sample_stb |=> $stable(hv_start) && $stable(lv_start)) else $error("start moved");
  op_needs_start_a: assert property (
    (hv_operate -> hv_start) && (lv_operate -> lv_start)) else $error("operate alone");
  hv_delay_win_a: assert property (
    $rose(hv_operate) |-> hv_cnt_ff >= lim_f(hv_cfg.delay_ms, -1) &&
      hv_cnt_ff <= lim_f(hv_cfg.delay_ms, 0)) else $error("hv delay off");
  lv_delay_win_a: assert property (
    $rose(lv_operate) |-> lv_cnt_ff >= lim_f(lv_cfg.delay_ms, -1) &&
      lv_cnt_ff <= lim_f(lv_cfg.delay_ms, 0)) else $error("lv delay off");
  rec_trig_a: assert property (
    !rec_busy && !rec_full && |hit |=> rec_busy && rec_trig_src == $past(hit))
    else $error("trigger missed");
  rec_len_a: assert property (
    $fell(rec_busy) |-> rec_full && wc_ff == 32'(efr_pkg::REC_DEPTH)) else $error("length");
  rec_hold_a: assert property (
    $fell(rec_full) |-> $past(rec_clear) && !rec_busy) else $error("record lost");
  cover property ($rose(hv_operate));
  cover property ($rose(hv_block));
  cover property ($rose(rec_full));
endmodule

bind efr_top efr_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .sample_stb(sample_stb), .samples(samples),
  .harm(harm), .ctrl_in(ctrl_in), .hv_cfg(hv_cfg), .lv_cfg(lv_cfg), .trig_mask(trig_mask),
  .trig_rise(trig_rise), .rec_clear(rec_clear), .hv_start(hv_start),
  .hv_operate(hv_operate), .hv_block(hv_block), .lv_start(lv_start),
  .lv_operate(lv_operate), .lv_block(lv_block), .rec_busy(rec_busy), .rec_full(rec_full),
  .rec_trig_src(rec_trig_src));

/* File: sim/efr_meas_model.sv */
// Measurement front-end model: strobed current samples
`timescale 1ns/1ps
module efr_meas_model (
  // Clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  sys_rst,
  // Values to present
  input  wire efr_pkg::efr_samples_t smp_in,
  input  wire efr_pkg::efr_harm_t    harm_in,
  // Stage side
  output logic                       sample_stb,
  output efr_pkg::efr_samples_t      samples,
  output efr_pkg::efr_harm_t         harm
);
  logic [1:0] div_ff;
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      div_ff <= 2'h0;
    end else begin
      div_ff <= div_ff + 2'h1;
    end
  end
  assign sample_stb = (div_ff == 2'h3);
  // Off-strobe values are scrambled so any stray sampling shows
  assign samples = sample_stb ? smp_in : ~smp_in;
  assign harm = sample_stb ? harm_in : ~harm_in;
endmodule

/* File: sim/tb_top.sv */
// Self-checking bench for the earth-fault stage and recorder
`timescale 1ns/1ps
module tb_top;
  localparam int T = 10;
  logic                   clk_sys, sys_rst, sample_stb, rec_clear;
  efr_pkg::efr_samples_t  smp, samples;
  efr_pkg::efr_harm_t     hrm, harm;
  efr_pkg::efr_side_cfg_t hv_cfg, lv_cfg;
  logic [4:0]             ctrl_in;
  logic [8:0]             trig_mask, trig_rise, rec_trig_src;
  logic [10:0]            rd_addr;
  logic                   hv_start, hv_operate, hv_block, lv_start, lv_operate, lv_block;
  logic                   rec_busy, rec_full;
  logic [136:0]           rec_rd_data;
  int                     error_cnt, cmp_count;

  efr_meas_model u_meas (.clk_sys(clk_sys), .sys_rst(sys_rst), .smp_in(smp), .harm_in(hrm),
    .sample_stb(sample_stb), .samples(samples), .harm(harm));
  efr_top #(.TICK_CYCLES(T)) DUT (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .sample_stb(sample_stb), .samples(samples),
    .harm(harm), .ctrl_in(ctrl_in), .hv_cfg(hv_cfg), .lv_cfg(lv_cfg), .trig_mask(trig_mask),
    .trig_rise(trig_rise), .rec_clear(rec_clear), .rd_addr(rd_addr), .hv_start(hv_start),
    .hv_operate(hv_operate), .hv_block(hv_block), .lv_start(lv_start),
    .lv_operate(lv_operate), .lv_block(lv_block), .rec_busy(rec_busy), .rec_full(rec_full),
    .rec_trig_src(rec_trig_src), .rec_rd_data(rec_rd_data));

  // ********
  // Tasks
  // ********
  task automatic end_of_test();
    if (error_cnt == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [136:0] got, input logic [136:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // Wait for n strobes; outputs are settled on return
  task automatic stb(input int n);
    int k;
    repeat (n) begin
      k = 0;
      while (sample_stb !== 1'b1) begin
        @(negedge clk_sys);
        k++;
        if (k > 8) begin
          error_cnt++;
          $display("ERROR %0t no sample strobe", $time);
          end_of_test();
        end
      end
      cyc(1);
    end
  endtask
  task automatic wait_full();
    int k;
    for (k = 0; k < 6000 && rec_full !== 1'b1; k++) cyc(1);
    chk(rec_full, 1'b1);
    if (rec_full !== 1'b1) end_of_test();
  endtask
  task automatic rd(input logic [10:0] a, input logic [136:0] exp);
    rd_addr = a;
    cyc(2);
    chk(rec_rd_data, exp);
  endtask
  // Both sides faulted together, HV delay d expected to act after ms
  task automatic op_run(input logic [16:0] d, input int ms);
    hv_cfg.threshold = 16'hFFFF;
    lv_cfg.threshold = 16'hFFFF;
    hv_cfg.delay_ms = d;
    stb(2);
    hv_cfg.threshold = 16'h00F9;
    lv_cfg.threshold = 16'h0190;
    stb(1);
    cyc((ms - 1) * T - 4);
    chk(hv_operate, 1'b0);
    cyc(T + 8);
    chk(hv_operate, 1'b1);
    chk(lv_operate, 1'b0);
    cyc(10 * T);
    chk(lv_operate, 1'b1);
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // ********
  // Sequence
  // ********
  initial begin
    error_cnt = 0;
    cmp_count = 0;
    sys_rst = 1'b1;
    rec_clear = 1'b0;
    smp = '0;
    hrm = '0;
    ctrl_in = 5'h00;
    hv_cfg = '{1'b1, 1'b0, 16'hFFFF, 17'h0_001E, 8'h00};
    lv_cfg = '{1'b0, 1'b0, 16'hFFFF, 17'h0_0028, 8'h00};
    trig_mask = 9'h010;
    trig_rise = 9'h1FF;
    rd_addr = 11'h000;
    repeat (5) @(posedge clk_sys);
    #1 sys_rst = 1'b0;
    // Residual sum 250 against thresholds just below and equal to it, then a negative sum
    smp.phase[0] = 16'h0064;
    smp.phase[1] = 16'h00C8;
    smp.phase[2] = 16'hFFCE;
    hv_cfg.threshold = 16'h00F9;
    stb(1);
    chk(hv_start, 1'b1);
    chk(lv_start, 1'b0);
    hv_cfg.threshold = 16'h00FA;
    stb(1);
    chk(hv_start, 1'b0);
    smp.phase[0] = 16'hFF9C;
    smp.phase[1] = 16'hFF9C;
    smp.phase[2] = 16'hFF9C;
    stb(1);
    chk(hv_start, 1'b1);
    // Definite time, clamped short delay, independent LV delay
    smp.phase[0] = 16'h0064;
    smp.phase[1] = 16'h00C8;
    smp.phase[2] = 16'hFFCE;
    smp.neutral[1] = 16'h01F4;
    op_run(17'h0_0005, 30);
    op_run(17'h0_001E, 30);
    // Start dropping before expiry restarts the timer
    hv_cfg.threshold = 16'hFFFF;
    stb(1);
    chk(hv_operate, 1'b0);
    hv_cfg.threshold = 16'h00F9;
    stb(1);
    cyc(20 * T);
    hv_cfg.threshold = 16'hFFFF;
    stb(1);
    chk(hv_operate, 1'b0);
    hv_cfg.threshold = 16'h00F9;
    stb(1);
    cyc(28 * T);
    chk(hv_operate, 1'b0);
    // Second-harmonic blocking in neutral mode, ignored in residual mode
    lv_cfg.threshold = 16'hFFFF;
    hv_cfg = '{1'b0, 1'b1, 16'h0064, 17'h0_001E, 8'h14};
    smp.neutral[0] = 16'h01F4;
    hrm.fund[0] = 16'h0064;
    hrm.h2[0] = 16'h001E;
    // LV sees a harmonic hit too, but its blocking is switched off
    hrm.h2[1] = 16'h001E;
    stb(1);
    chk(hv_block, 1'b1);
    chk(lv_block, 1'b0);
    chk(hv_start, 1'b0);
    cyc(40 * T);
    chk(hv_operate, 1'b0);
    hv_cfg.h2_ratio_pct = 8'h1E;
    stb(1);
    chk(hv_block, 1'b0);
    chk(hv_start, 1'b1);
    hv_cfg.h2_ratio_pct = 8'h14;
    hv_cfg.residual_sel = 1'b1;
    stb(1);
    chk(hv_start, 1'b1);
    chk(hv_block, 1'b0);
    // Recorder: rising trigger, refusals while busy and full, readout
    hv_cfg.threshold = 16'hFFFF;
    stb(2);
    for (int k = 0; k < 6; k++) smp.phase[k] = 16'h1000 + 16'(k);
    smp.neutral[0] = 16'h2000;
    smp.neutral[1] = 16'h2001;
    ctrl_in = 5'h01;
    cyc(1);
    chk(rec_busy, 1'b1);
    chk(rec_trig_src, 9'h010);
    ctrl_in = 5'h00;
    rec_clear = 1'b1;
    cyc(1);
    ctrl_in = 5'h01;
    rec_clear = 1'b0;
    cyc(1);
    chk(rec_busy, 1'b1);
    chk(rec_trig_src, 9'h010);
    wait_full();
    rd(11'h4AF, {9'h010, smp.neutral, smp.phase});
    rd(11'h258, {9'h010, smp.neutral, smp.phase});
    ctrl_in = 5'h00;
    cyc(1);
    ctrl_in = 5'h01;
    cyc(2);
    chk(rec_busy, 1'b0);
    chk(rec_full, 1'b1);
    rec_clear = 1'b1;
    cyc(1);
    rec_clear = 1'b0;
    cyc(1);
    chk(rec_full, 1'b0);
    chk(rec_trig_src, 9'h000);
    // Falling-edge trigger
    trig_rise = 9'h1EF;
    ctrl_in = 5'h00;
    cyc(1);
    chk(rec_busy, 1'b1);
    chk(rec_trig_src, 9'h010);
    wait_full();
    rd(11'h000, {9'h000, smp.neutral, smp.phase});
    rec_clear = 1'b1;
    cyc(1);
    rec_clear = 1'b0;
    end_of_test();
  end
endmodule
